// file: alu_branch_pkg.sv
// Constants for the byte ALU and conditional branch decoder.
// Assumes an APB master on pclk and a same-cycle data memory read port.
package alu_branch_pkg;
    // APB register byte addresses
    localparam int APB_AW = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_WREG = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_BANK = 8'h0c;
    localparam logic [7:0] ADDR_PC = 8'h10;
    localparam logic [7:0] ADDR_FSR = 8'h14;
    // Control bits
    localparam int CTRL_RUN = 0;
    localparam int CTRL_EXT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // Status bit positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_N = 4;
    // Opcode fields
    localparam logic [5:0] OPC_ADD = 6'h09;
    localparam logic [5:0] OPC_ADDC = 6'h08;
    localparam logic [5:0] OPC_ANDF = 6'h05;
    localparam logic [7:0] OPC_ANDL = 8'h0b;
    localparam logic [3:0] OPC_BCF = 4'h9;
    localparam logic [7:0] OPC_BC = 8'he2;
    localparam logic [7:0] OPC_BNC = 8'he3;
    localparam logic [7:0] OPC_BN = 8'he6;
    localparam logic [7:0] OPC_BNN = 8'he7;
    // Data address map
    localparam int BANK_W = 4;
    localparam logic [7:0] IDX_LIMIT = 8'h5f;
    localparam logic [7:0] ACC_SPLIT = 8'h60;
    localparam logic [3:0] ACC_LOW_BANK = 4'h0;
    localparam logic [3:0] ACC_SFR_BANK = 4'hf;
    // Quarter-cycle phases
    localparam logic [1:0] Q_DECODE = 2'h0;
    localparam logic [1:0] Q_READ = 2'h1;
    localparam logic [1:0] Q_PROC = 2'h2;
    localparam logic [1:0] Q_WRITE = 2'h3;
    // Instruction cycle state
    typedef enum logic [1:0] {
        CYC_EXEC = 2'b01,
        CYC_FLUSH = 2'b10
    } cyc_e;
endpackage

// file: byte_alu_branch_decode.sv
// Decode and execute of add, AND, bit clear and carry/negative branches.
// Assumes fetch presents the word at fetch_pc and memory reads same-cycle.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
// Contract
// - Decode 001001da as add W to file
// - d=0 writes W, d=1 writes file
// - Decode 001000da as add with carry
// - Adds update N, OV, C, DC, Z
// - a=0 access bank, a=1 uses bank register
// - a=0, extended, f<=95 uses indexed offset
// - Decode 00001011 as AND literal into W
// - Decode 000101da as AND W with file
// - ANDs update only N and Z
// - Decode 11100010 as branch if carry set
// - Decode 11100011 as branch if carry clear
// - Decode 11100110 as branch if negative set
// - Decode 11100111 as branch if negative clear
// - Offset is signed, doubled, added to counter
// - Taken target is address plus 2 plus 2n
// - Branch one cycle, two when taken
// - Decode 1001bbba as clear indexed file bit
// - These ALU ops take one word, one cycle
// - Counter change costs one extra nop cycle
module byte_alu_branch_decode #(
    parameter int PC_W = 21,
    parameter int ADDR_W = 12
) (
    input wire logic pclk, // 200 MHz clock
    input wire logic presetn, // Async reset, active low
    input wire logic [alu_branch_pkg::APB_AW-1:0] paddr, // APB address
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // Unmapped address
    input wire logic [15:0] instr_word, // Fetched instruction
    input wire logic instr_valid, // Fetched word valid
    output logic instr_take, // Word consumed this pclk
    output logic [PC_W-1:0] fetch_pc, // Program counter
    output logic [ADDR_W-1:0] mem_addr, // Data memory address
    input wire logic [7:0] mem_rdata, // Data memory read data
    output logic [7:0] mem_wdata, // Data memory write data
    output logic mem_we // Data memory write strobe
);
    import alu_branch_pkg::*;

    logic [1:0] q_reg, q_next;
    cyc_e cyc_reg, cyc_next;
    logic [15:0] ir_reg, ir_next;
    logic ir_ok_reg, ir_ok_next;
    logic [7:0] opnd_reg, opnd_next;
    logic [7:0] res_reg, res_next;
    logic [4:0] flg_reg, flg_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic we_reg, we_next;
    logic [7:0] wdata_reg, wdata_next;
    logic [1:0] ctrl_reg, ctrl_next;
    logic [7:0] w_reg, w_next;
    logic [4:0] status_reg, status_next;
    logic [BANK_W-1:0] bank_reg, bank_next;
    logic [PC_W-1:0] pc_reg, pc_next;
    logic [ADDR_W-1:0] fsr_reg, fsr_next;
    logic [31:0] prdata_reg, prdata_next;
    logic err_reg, err_next;
    logic run, apb_wr, apb_setup;
    logic op_add, op_addc, op_andl, op_andf, op_bcf;
    logic op_bc, op_bnc, op_bn, op_bnn, op_br, br_take;
    logic to_file, to_w, byte_op;
    logic [PC_W-1:0] off2, br_target;
    logic [4:0] lo_sum;
    logic [8:0] sum9;
    logic cin;
    logic [7:0] f_lit;

    assign run = ctrl_reg[CTRL_RUN];

    // Instruction decode from the latched word
    assign op_add = ir_ok_reg && (ir_reg[15:10] == OPC_ADD);
    assign op_addc = ir_ok_reg && (ir_reg[15:10] == OPC_ADDC);
    assign op_andf = ir_ok_reg && (ir_reg[15:10] == OPC_ANDF);
    assign op_andl = ir_ok_reg && (ir_reg[15:8] == OPC_ANDL);
    assign op_bcf = ir_ok_reg && (ir_reg[15:12] == OPC_BCF);
    assign op_bc = ir_ok_reg && (ir_reg[15:8] == OPC_BC);
    assign op_bnc = ir_ok_reg && (ir_reg[15:8] == OPC_BNC);
    assign op_bn = ir_ok_reg && (ir_reg[15:8] == OPC_BN);
    assign op_bnn = ir_ok_reg && (ir_reg[15:8] == OPC_BNN);
    assign op_br = op_bc || op_bnc || op_bn || op_bnn;
    assign br_take = (op_bc && status_reg[ST_C]) || (op_bnc && !status_reg[ST_C])
        || (op_bn && status_reg[ST_N]) || (op_bnn && !status_reg[ST_N]);
    assign byte_op = op_add || op_addc || op_andf;
    // Destination bit: 0 to W, 1 back to file
    assign to_w = (byte_op && !ir_reg[9]) || op_andl;
    assign to_file = (byte_op && ir_reg[9]) || op_bcf;

    // Signed offset doubled, added to the branch's own counter plus 2
    assign off2 = {{(PC_W-9){ir_reg[7]}}, ir_reg[7:0], 1'b0};
    assign br_target = pc_reg + PC_W'(2) + off2;

    // Adder with optional carry in; nibble sum gives digit carry
    assign cin = op_addc ? status_reg[ST_C] : 1'b0;
    assign lo_sum = {1'b0, w_reg[3:0]} + {1'b0, opnd_reg[3:0]} + {4'h0, cin};
    assign sum9 = {1'b0, w_reg} + {1'b0, opnd_reg} + {8'h00, cin};
    assign f_lit = instr_word[7:0];

    // Handshake to fetch: one word per instruction cycle, none in flush
    assign instr_take = run && (q_reg == Q_DECODE) && (cyc_reg == CYC_EXEC);
    assign fetch_pc = pc_reg;
    assign mem_addr = addr_reg;
    assign mem_we = we_reg;
    assign mem_wdata = wdata_reg;
    assign prdata = prdata_reg;
    assign pslverr = err_reg;
    assign pready = 1'b1;

    // Execute pipeline: decode, read, process, write per quarter
    always_comb begin
        q_next = q_reg;
        cyc_next = cyc_reg;
        ir_next = ir_reg;
        ir_ok_next = ir_ok_reg;
        opnd_next = opnd_reg;
        res_next = res_reg;
        flg_next = flg_reg;
        addr_next = addr_reg;
        we_next = 1'b0;
        wdata_next = wdata_reg;
        if (run) begin
            q_next = q_reg + 2'h1;
            case (q_reg)
                Q_DECODE: begin
                    ir_next = instr_word;
                    ir_ok_next = instr_valid && (cyc_reg == CYC_EXEC);
                    if (instr_word[8]) begin
                        addr_next = {bank_reg, f_lit};
                    end else if (ctrl_reg[CTRL_EXT] && (f_lit <= IDX_LIMIT)) begin
                        addr_next = fsr_reg + {4'h0, f_lit};
                    end else if (f_lit < ACC_SPLIT) begin
                        addr_next = {ACC_LOW_BANK, f_lit};
                    end else begin
                        addr_next = {ACC_SFR_BANK, f_lit};
                    end
                end
                Q_READ: begin
                    opnd_next = mem_rdata;
                end
                Q_PROC: begin
                    flg_next = status_reg;
                    if (op_add || op_addc) begin
                        res_next = sum9[7:0];
                        flg_next[ST_C] = sum9[8];
                        flg_next[ST_DC] = lo_sum[4];
                        flg_next[ST_OV] = (w_reg[7] == opnd_reg[7])
                            && (sum9[7] != w_reg[7]);
                    end else if (op_andl) begin
                        res_next = w_reg & ir_reg[7:0];
                    end else if (op_andf) begin
                        res_next = w_reg & opnd_reg;
                    end else begin
                        // Only the indexed bit drops; others pass through
                        res_next = opnd_reg & ~(8'h01 << ir_reg[11:9]);
                    end
                    flg_next[ST_Z] = (res_next == 8'h00);
                    flg_next[ST_N] = res_next[7];
                    we_next = to_file;
                    wdata_next = res_next;
                end
                Q_WRITE: begin
                    // Flush cycle is a nop while the target is fetched
                    cyc_next = br_take ? CYC_FLUSH : CYC_EXEC;
                end
                default: begin
                    q_next = Q_DECODE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_reg <= Q_DECODE;
            cyc_reg <= CYC_EXEC;
            ir_reg <= 16'h0000;
            ir_ok_reg <= 1'b0;
            opnd_reg <= 8'h00;
            res_reg <= 8'h00;
            flg_reg <= 5'h00;
            addr_reg <= '0;
            we_reg <= 1'b0;
            wdata_reg <= 8'h00;
        end else begin
            q_reg <= q_next;
            cyc_reg <= cyc_next;
            ir_reg <= ir_next;
            ir_ok_reg <= ir_ok_next;
            opnd_reg <= opnd_next;
            res_reg <= res_next;
            flg_reg <= flg_next;
            addr_reg <= addr_next;
            we_reg <= we_next;
            wdata_reg <= wdata_next;
        end
    end

    // Architectural state; core write in the last quarter beats APB
    assign apb_wr = psel && penable && pwrite;
    assign apb_setup = psel && !penable;
    always_comb begin
        ctrl_next = ctrl_reg;
        w_next = w_reg;
        status_next = status_reg;
        bank_next = bank_reg;
        pc_next = pc_reg;
        fsr_next = fsr_reg;
        if (apb_wr) begin
            case (paddr)
                ADDR_CTRL: ctrl_next = pwdata[1:0];
                ADDR_WREG: w_next = pwdata[7:0];
                ADDR_STATUS: status_next = pwdata[4:0];
                ADDR_BANK: bank_next = pwdata[BANK_W-1:0];
                ADDR_PC: pc_next = pwdata[PC_W-1:0];
                ADDR_FSR: fsr_next = pwdata[ADDR_W-1:0];
                default: ;
            endcase
        end
        if (run && (q_reg == Q_WRITE) && ir_ok_reg) begin
            // Every instruction here is a single word; a taken branch adds a flush cycle
            pc_next = br_take ? br_target : pc_reg + PC_W'(2);
            if (to_w) begin
                w_next = res_reg;
            end
            if (op_add || op_addc) begin
                status_next = flg_reg;
            end else if (op_andl || op_andf) begin
                status_next[ST_Z] = flg_reg[ST_Z];
                status_next[ST_N] = flg_reg[ST_N];
            end else begin
                status_next = status_reg;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
            w_reg <= 8'h00;
            status_reg <= 5'h00;
            bank_reg <= '0;
            pc_reg <= '0;
            fsr_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            w_reg <= w_next;
            status_reg <= status_next;
            bank_reg <= bank_next;
            pc_reg <= pc_next;
            fsr_reg <= fsr_next;
        end
    end

    // APB read data captured in setup so the access phase is zero-wait
    always_comb begin
        prdata_next = prdata_reg;
        err_next = err_reg;
        if (apb_setup) begin
            prdata_next = 32'h00000000;
            err_next = 1'b0;
            case (paddr)
                ADDR_CTRL: prdata_next[1:0] = ctrl_reg;
                ADDR_WREG: prdata_next[7:0] = w_reg;
                ADDR_STATUS: prdata_next[4:0] = status_reg;
                ADDR_BANK: prdata_next[BANK_W-1:0] = bank_reg;
                ADDR_PC: prdata_next[PC_W-1:0] = pc_reg;
                ADDR_FSR: prdata_next[ADDR_W-1:0] = fsr_reg;
                default: err_next = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
            err_reg <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            err_reg <= err_next;
        end
    end

    // Checks on the execute path
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic last_q;
    assign last_q = run && (q_reg == Q_WRITE) && ir_ok_reg && !apb_wr;

    sequence s_taken;
        last_q && br_take;
    endsequence
    sequence s_flush4;
        (cyc_reg == CYC_FLUSH && !instr_take)[*4];
    endsequence

    a_branch_target: assert property (s_taken |=> pc_reg == $past(br_target))
        else $error("taken branch target wrong");
    // Run is already part of last_q, so the sequence alone starts the check
    a_flush_nop: assert property (s_taken |=> s_flush4 ##1 cyc_reg == CYC_EXEC)
        else $error("taken branch lacks one nop cycle");
    a_no_take_step: assert property (last_q && op_br && !br_take
        |=> pc_reg == $past(pc_reg) + PC_W'(2) && cyc_reg == CYC_EXEC)
        else $error("untaken branch did not step by 2");
    a_flush_quiet: assert property (cyc_reg == CYC_FLUSH |-> !mem_we)
        else $error("write during flush cycle");
    a_and_flags_kept: assert property (last_q && (op_andl || op_andf)
        |=> status_reg[ST_C] == $past(status_reg[ST_C])
        && status_reg[ST_OV] == $past(status_reg[ST_OV])
        && status_reg[ST_DC] == $past(status_reg[ST_DC]))
        else $error("AND changed C, DC or OV");
    a_branch_flags_kept: assert property (last_q && (op_br || op_bcf)
        |=> status_reg == $past(status_reg))
        else $error("branch or bit clear changed flags");
    a_bcf_bit_low: assert property (mem_we && op_bcf
        |-> mem_wdata[ir_reg[11:9]] == 1'b0 && $stable(ir_reg))
        else $error("bit clear left bit set");
    // The next instruction may write memory, so look only at this write quarter
    a_dest_w_no_write: assert property (run && q_reg == Q_PROC && byte_op && !ir_reg[9]
        |=> !mem_we ##1 (!$past(run) || w_reg == $past(res_reg)))
        else $error("W destination wrote memory or W not loaded");
    a_add_carry_out: assert property (run && q_reg == Q_PROC && (op_add || op_addc)
        && !apb_wr ##1 !apb_wr |=> status_reg[ST_C] == $past(sum9[8], 2))
        else $error("add carry flag wrong");
    a_bank_select: assert property (run && q_reg == Q_DECODE && instr_word[8]
        |=> mem_addr == {$past(bank_reg), $past(instr_word[7:0])})
        else $error("banked address wrong");
endmodule // byte_alu_branch_decode

// file: fetch_mem_model.sv
// Fetch stage and banked data memory facing the decoder.
// Assumes the bench loads prog and mem by hierarchical reference.
`timescale 1ns/1ps
module fetch_mem_model (
    input wire logic pclk, // Core clock
    input wire logic [20:0] fetch_pc, // Program counter
    output logic [15:0] instr_word, // Word at the counter
    output logic instr_valid, // Fetch always ready
    input wire logic [11:0] mem_addr, // Data address
    output logic [7:0] mem_rdata, // Same-cycle read data
    input wire logic [7:0] mem_wdata, // Write data
    input wire logic mem_we // Write strobe
);
    logic [15:0] prog [0:255];
    logic [7:0] mem [0:4095];
    // Unloaded words read as zero, a no-op, so stray fetches stay harmless
    assign instr_word = prog[fetch_pc[8:1]];
    assign instr_valid = 1'b1;
    assign mem_rdata = mem[mem_addr];
    // Write lands at the edge that ends the write quarter
    always @(posedge pclk) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule // fetch_mem_model

// file: byte_alu_branch_decode_bench.sv
// Self-checking bench for the byte ALU and branch decoder.
// Assumes fetch_mem_model as fetch stage and data memory.
`timescale 1ns/1ps
module byte_alu_branch_decode_bench;
    import alu_branch_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, instr_valid, instr_take, mem_we, err;
    logic [15:0] instr_word;
    logic [20:0] fetch_pc;
    logic [11:0] mem_addr;
    logic [7:0] mem_rdata, mem_wdata;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    byte_alu_branch_decode byte_alu_branch_decode_i (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_word(instr_word),
        .instr_valid(instr_valid), .instr_take(instr_take), .fetch_pc(fetch_pc),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we));
    fetch_mem_model fetch_mem_model_i (.pclk(pclk), .fetch_pc(fetch_pc),
        .instr_word(instr_word), .instr_valid(instr_valid), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we));
    // Free-running 200 MHz clock
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    // Hang guard, far above the several hundred cycles the cases need
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Fresh reset, one instruction, then counter, flush gap and results
    task automatic run_case(input logic [15:0] ins, input logic [7:0] w, st, bank,
        input logic [31:0] ctl, input logic [11:0] ma, input logic [7:0] mv, ew, est, emv,
        input logic [20:0] epc, input int egap);
        int g;
        g = 0;
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        fetch_mem_model_i.prog[0] = ins;
        fetch_mem_model_i.mem[ma] = mv;
        apb(1'b1, ADDR_WREG, {24'h0, w});
        apb(1'b1, ADDR_STATUS, {24'h0, st});
        apb(1'b1, ADDR_BANK, {24'h0, bank});
        apb(1'b1, ADDR_FSR, 32'h300);
        apb(1'b1, ADDR_CTRL, ctl);
        while (fetch_pc === 21'h0 && g < 40) begin
            @(posedge pclk);
            #1;
            g++;
        end
        check({11'h0, fetch_pc}, {11'h0, epc});
        g = 0;
        while (instr_take !== 1'b1 && g < 20) begin
            @(posedge pclk);
            #1;
            g++;
        end
        check(g, egap);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b0, ADDR_WREG, 32'h0);
        check(rd, {24'h0, ew});
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd, {24'h0, est});
        check({24'h0, fetch_mem_model_i.mem[ma]}, {24'h0, emv});
    endtask
    initial begin
        for (int i = 0; i < 256; i++) begin
            fetch_mem_model_i.prog[i] = 16'h0000;
        end
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Registers clear after reset; unmapped word errors and reads zero
        for (int a = 0; a <= 8'h14; a += 4) begin
            apb(1'b0, a[7:0], 32'h0);
            check(rd, 32'h0);
        end
        apb(1'b0, 8'h18, 32'h0);
        check({rd[30:0], err}, 32'h1);
        run_case(16'h2520, 8'h17, 8'h00, 8'h02, 1, 12'h220, 8'hc2,
            8'hd9, 8'h10, 8'hc2, 2, 0);
        run_case(16'h2670, 8'h80, 8'h00, 8'h00, 3, 12'hf70, 8'h80,
            8'h80, 8'h0d, 8'h00, 2, 0);
        run_case(16'h2102, 8'h4d, 8'h01, 8'h00, 1, 12'h002, 8'h02,
            8'h50, 8'h02, 8'h02, 2, 0);
        run_case(16'h225f, 8'h0f, 8'h00, 8'h00, 3, 12'h35f, 8'h01,
            8'h0f, 8'h02, 8'h10, 2, 0);
        run_case(16'h0b5f, 8'ha3, 8'h0f, 8'h00, 1, 12'h000, 8'h00,
            8'h03, 8'h0b, 8'h00, 2, 0);
        run_case(16'h1460, 8'h17, 8'h17, 8'h00, 3, 12'hf60, 8'hc2,
            8'h02, 8'h03, 8'hc2, 2, 0);
        run_case(16'h1733, 8'h8f, 8'h04, 8'h05, 1, 12'h533, 8'hf0,
            8'h8f, 8'h10, 8'h80, 2, 0);
        run_case(16'h9e05, 8'h55, 8'h1f, 8'h00, 1, 12'h005, 8'hc7,
            8'h55, 8'h1f, 8'h47, 2, 0);
        run_case(16'he205, 8'h11, 8'h01, 8'h00, 1, 12'h000, 8'h00,
            8'h11, 8'h01, 8'h00, 12, 4);
        run_case(16'he205, 8'h11, 8'h1e, 8'h00, 1, 12'h000, 8'h00,
            8'h11, 8'h1e, 8'h00, 2, 0);
        run_case(16'he380, 8'h11, 8'h00, 8'h00, 1, 12'h000, 8'h00, 8'h11, 8'h00, 8'h00,
            21'h1fff02, 4);
        run_case(16'he380, 8'h11, 8'h01, 8'h00, 1, 12'h000, 8'h00,
            8'h11, 8'h01, 8'h00, 2, 0);
        run_case(16'he67f, 8'h11, 8'h10, 8'h00, 1, 12'h000, 8'h00, 8'h11, 8'h10, 8'h00,
            21'h100, 4);
        run_case(16'he67f, 8'h11, 8'h0f, 8'h00, 1, 12'h000, 8'h00,
            8'h11, 8'h0f, 8'h00, 2, 0);
        run_case(16'he7fe, 8'h11, 8'h00, 8'h00, 1, 12'h000, 8'h00, 8'h11, 8'h00, 8'h00,
            21'h1ffffe, 4);
        run_case(16'he7fe, 8'h11, 8'h10, 8'h00, 1, 12'h000, 8'h00,
            8'h11, 8'h10, 8'h00, 2, 0);
        end_sim();
    end
endmodule // byte_alu_branch_decode_bench
